// ---- mmicp_combiner.sv ----
// file: mac and management-serial interrupt combiner with pacing timer and avalon registers
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/10ps
// ============================================================
// Behaviour
// R1: all mac and management-serial interrupt lines are merged into one cpu interrupt.
// R2: a cause vector shows, one mclk later, the twenty source bits, each link and management-serial pair ORed into one.
// R3: with the global enable at 0 the combined interrupt is held low.
// R4: with the global enable at 1 any active source raises the combined interrupt.
// R5: setting the enable again with sources pending raises the output anew.
// R6: software clears the enable on entry and sets it again after clearing its sources.
// R7: each enabling loads the programmed pacing count into the down-counter.
// R8: no further combined interrupt is raised until the pacing counter reaches zero.
// R9: the pacing counter steps down at one sixth of the pll rate.
// R10: the pacing count resets to zero and accepts values up to 1FFFF.
// R11: the gate control register holds the enable in bit 0, other bits read zero.
// R12: in the idle state clocks stop and all register values are kept.
// R13: the synchronized reset returns all registers to their defaults.
// R14: the pacing counter loads only on a 0 to 1 change of the enable.
// R15: the output rises only with a source active, enable set and counter at zero.
// R16: the combined output comes from a register clocked by mclk.
module mmicp_combiner (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pll rate enable pulse
	input wire logic pll_tick,
	// interrupt sources
	input wire logic [7:0] tx_channel_irq,
	input wire logic [7:0] rx_channel_irq,
	input wire logic counter_overflow_irq,
	input wire logic descriptor_error_irq,
	input wire logic [1:0] link_change_irq,
	input wire logic [1:0] mgmt_cmd_done_irq,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// outputs
	output logic combined_cpu_irq,
	output logic [mmicp_pkg::SRC_W-1:0] irq_cause_vector,
	output logic status_irq
);
	// ============================================================
	// sources
	logic [mmicp_pkg::SRC_W-1:0] src;
	logic any_src;

	assign src[mmicp_pkg::TX_LSB +: 8] = tx_channel_irq;
	assign src[mmicp_pkg::RX_LSB +: 8] = rx_channel_irq;
	assign src[mmicp_pkg::STAT_BIT] = counter_overflow_irq;
	assign src[mmicp_pkg::HOST_BIT] = descriptor_error_irq;
	assign src[mmicp_pkg::LINK_BIT] = |link_change_irq;
	assign src[mmicp_pkg::USER_BIT] = |mgmt_cmd_done_irq;
	assign any_src = |src; // R1

	// ============================================================
	// bus handshake
	// one wait cycle per access, so read data come straight from a flop
	logic acc_r;
	logic acc;
	logic wr_go;
	logic rd_go;

	assign acc = (avs_read || avs_write) && !acc_r;
	assign wr_go = avs_write && acc_r;
	assign rd_go = avs_read && acc_r;

	// ============================================================
	// registers
	// idle state just stops mclk; nothing here reinitialises on resume
	logic gate_r; // R12
	logic gate_nxt;
	logic [mmicp_pkg::PACE_W-1:0] pace_cfg_r;
	logic [mmicp_pkg::PACE_W-1:0] pace_cfg_nxt;
	logic [mmicp_pkg::PACE_W-1:0] pace_cnt_r;
	logic [mmicp_pkg::PACE_W-1:0] pace_cnt_nxt;
	logic [mmicp_pkg::EV_W-1:0] stat_r;
	logic [mmicp_pkg::EV_W-1:0] stat_nxt;
	logic [mmicp_pkg::EV_W-1:0] mask_r;
	logic [mmicp_pkg::EV_W-1:0] mask_nxt;
	logic irq_nxt;
	logic div_tick;

	wire sel_gate = avs_address == mmicp_pkg::OFS_GATE_CONTROL;
	wire sel_pace = avs_address == mmicp_pkg::OFS_PACING_COUNT;
	wire sel_stat = avs_address == mmicp_pkg::OFS_IRQ_STATUS;
	wire sel_mask = avs_address == mmicp_pkg::OFS_IRQ_MASK;
	wire [2:0] lane_hi = {avs_byteenable[2], avs_byteenable[1], avs_byteenable[0]};

	assign gate_nxt = (wr_go && sel_gate && avs_byteenable[0])
		? avs_writedata[mmicp_pkg::ENABLE_BIT] : gate_r; // R11

	// byte-wise write of the 17-bit count, bit 16 in lane 2
	assign pace_cfg_nxt = (wr_go && sel_pace) ? {
		lane_hi[2] ? avs_writedata[16] : pace_cfg_r[16],
		lane_hi[1] ? avs_writedata[15:8] : pace_cfg_r[15:8],
		lane_hi[0] ? avs_writedata[7:0] : pace_cfg_r[7:0]} : pace_cfg_r; // R10

	wire enable_rise = gate_nxt && !gate_r; // R14
	wire pace_zero = pace_cnt_r == mmicp_pkg::PACE_RESET;

	// load only on the rising enable, otherwise count down on the divided tick
	assign pace_cnt_nxt = enable_rise ? pace_cfg_r // R7
		: ((div_tick && !pace_zero) ? pace_cnt_r - 17'h00001 : pace_cnt_r); // R9

	// enable low forces the line low; enable high passes sources once paced out
	assign irq_nxt = gate_r && pace_zero && any_src; // R3 R4 R8 R15

	// ============================================================
	// event status, write one to clear, set wins over clear
	wire [mmicp_pkg::EV_W-1:0] ev;
	wire [mmicp_pkg::EV_W-1:0] w1c;

	assign ev[mmicp_pkg::EV_ASSERT] = irq_nxt && !combined_cpu_irq;
	assign ev[mmicp_pkg::EV_ENABLE] = enable_rise;
	assign ev[mmicp_pkg::EV_EXPIRE] = div_tick &&
		(pace_cnt_r == 17'h00001) && !enable_rise;
	assign w1c = (wr_go && sel_stat && avs_byteenable[0])
		? avs_writedata[mmicp_pkg::EV_W-1:0] : '0;
	assign stat_nxt = (stat_r & ~w1c) | ev;
	assign mask_nxt = (wr_go && sel_mask && avs_byteenable[0])
		? avs_writedata[mmicp_pkg::EV_W-1:0] : mask_r;

	// ============================================================
	// read mux
	logic [31:0] rdata;

	always_comb begin
		rdata = 32'h00000000;
		if (sel_gate) begin
			rdata[mmicp_pkg::ENABLE_BIT] = gate_r;
		end else if (sel_pace) begin
			rdata[mmicp_pkg::PACE_W-1:0] = pace_cfg_r;
		end else if (sel_stat) begin
			rdata[mmicp_pkg::EV_W-1:0] = stat_r;
		end else if (sel_mask) begin
			rdata[mmicp_pkg::EV_W-1:0] = mask_r;
		end
	end

	// ============================================================
	// pacing tick divider
	mmicp_tick_div #(
		.DIV(mmicp_pkg::PLL_DIV)
	) u_div (
		.mclk(mclk),
		.rst(rst),
		.pll_tick(pll_tick),
		.div_tick(div_tick)
	);

	// ============================================================
	// flops; the power controller's synchronized reset drives rst
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gate_r <= mmicp_pkg::GATE_RESET; // R13
			pace_cfg_r <= mmicp_pkg::PACE_RESET;
			pace_cnt_r <= mmicp_pkg::PACE_RESET;
			stat_r <= '0;
			mask_r <= '0;
			acc_r <= 1'b0;
		end else begin
			gate_r <= gate_nxt;
			pace_cfg_r <= pace_cfg_nxt;
			pace_cnt_r <= pace_cnt_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			acc_r <= acc;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			combined_cpu_irq <= 1'b0;
			irq_cause_vector <= '0;
			status_irq <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			combined_cpu_irq <= irq_nxt; // R16 R5
			irq_cause_vector <= src; // R2
			status_irq <= |(stat_nxt & mask_nxt);
			avs_readdata <= acc ? rdata : avs_readdata;
		end
	end

	// waitrequest high in the first cycle of each access
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !acc;
		end
	end
endmodule

// ---- mmicp_pkg.sv ----
// package: register map, field layout and timing constants of the interrupt combiner
package mmicp_pkg;
	// register byte offsets
	localparam logic [3:0] OFS_GATE_CONTROL = 4'h4;
	localparam logic [3:0] OFS_PACING_COUNT = 4'h8;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'hC;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h0;
	// field layout
	localparam int ENABLE_BIT = 0;
	localparam int PACE_W = 17;
	localparam int SRC_W = 20;
	localparam int TX_LSB = 0;
	localparam int RX_LSB = 8;
	localparam int STAT_BIT = 16;
	localparam int HOST_BIT = 17;
	localparam int LINK_BIT = 18;
	localparam int USER_BIT = 19;
	// event bits: irq_assert, enable_rise, pace_expired
	localparam int EV_W = 3;
	localparam int EV_ASSERT = 0;
	localparam int EV_ENABLE = 1;
	localparam int EV_EXPIRE = 2;
	// reset values
	localparam logic GATE_RESET = 1'b0;
	localparam logic [PACE_W-1:0] PACE_RESET = 17'h00000;
	localparam logic [PACE_W-1:0] PACE_MAX = 17'h1FFFF;
	// pacing tick: pll rate divided by six
	localparam int PLL_DIV = 6;
	localparam logic [2:0] DIV_LAST = 3'(PLL_DIV - 1);
endpackage

// ---- mmicp_tick_div.sv ----
// file: divider making a one-cycle enable pulse at one sixth of the pll rate
`timescale 1ns/10ps
module mmicp_tick_div #(
	parameter int DIV = mmicp_pkg::PLL_DIV
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// pll rate enable in, divided enable out
	input wire logic pll_tick,
	output logic div_tick
);
	localparam logic [2:0] LAST = 3'(DIV - 1);

	logic [2:0] cnt_r;
	logic [2:0] cnt_nxt;
	logic wrap;

	assign wrap = pll_tick && (cnt_r == LAST);
	assign cnt_nxt = wrap ? 3'h0 : (pll_tick ? cnt_r + 3'h1 : cnt_r);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= 3'h0;
			div_tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			div_tick <= wrap; // R9
		end
	end
endmodule

// ---- mmicp_cpu_intc.sv ----
// cpu interrupt controller model: counts rising edges of the combined line
`timescale 1ns/10ps
module mmicp_cpu_intc (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// combined line in, edge count out
	input wire logic irq_in,
	output int edges
);
	logic last_r;
	// edge sensitive: a level held high is one request only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			last_r <= 1'b0;
			edges <= 0;
		end else begin
			last_r <= irq_in;
			if (irq_in && !last_r) begin
				edges <= edges + 1;
			end
		end
	end
endmodule

// ---- mmicp_combiner_monitor.sv ----
// checker: bus timing, gating, pacing config and cause copy
`timescale 1ns/10ps
module mmicp_combiner_monitor (
	// clock, reset, bus
	input wire logic mclk, rst, avs_read, avs_write, avs_waitrequest,
	input wire logic [3:0] avs_address, avs_byteenable,
	input wire logic [31:0] avs_writedata, avs_readdata,
	// sources and outputs
	input wire logic [7:0] tx_channel_irq, rx_channel_irq,
	input wire logic [1:0] link_change_irq,
	input wire logic combined_cpu_irq,
	input wire logic [mmicp_pkg::SRC_W-1:0] irq_cause_vector
);
	logic en_r;
	logic [16:0] cfg_r;
	// full-word writes only; the bench never narrows byteenable
	wire wr_done = avs_write && !avs_waitrequest && avs_byteenable == 4'hF;
	wire rd_done = avs_read && !avs_waitrequest;
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			en_r <= 1'b0;
			cfg_r <= 17'h0;
		end else if (wr_done && avs_address == 4'h4) begin
			en_r <= avs_writedata[0];
		end else if (wr_done && avs_address == 4'h8) begin
			cfg_r <= avs_writedata[16:0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	chk_gate_off: assert property (!en_r |=> !combined_cpu_irq)
		else $error("irq high while disabled");
	chk_irq_rise: assert property (en_r && cfg_r == 17'h0 && |tx_channel_irq |=> combined_cpu_irq)
		else $error("irq missing");
	chk_rise_cause: assert property ($rose(combined_cpu_irq) |-> $past(en_r) && |irq_cause_vector)
		else $error("irq rose without cause");
	chk_cause_copy: assert property (irq_cause_vector[15:0] == {$past(rx_channel_irq), $past(tx_channel_irq)})
		else $error("cause vector wrong");
	chk_link_or: assert property (irq_cause_vector[18] == $past(|link_change_irq))
		else $error("link cause wrong");
	chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_gate_read: assert property (rd_done && avs_address == 4'h4 |-> avs_readdata == 32'(en_r))
		else $error("gate readback wrong");
	chk_pace_read: assert property (rd_done && avs_address == 4'h8 |-> avs_readdata == 32'(cfg_r))
		else $error("pacing readback wrong");
	cover property ($rose(combined_cpu_irq));
	cover property ($fell(combined_cpu_irq));
	cover property (rd_done);
endmodule
bind mmicp_combiner mmicp_combiner_monitor u_mon (.mclk, .rst, .avs_read, .avs_write,
	.avs_waitrequest, .avs_address, .avs_byteenable, .avs_writedata, .avs_readdata,
	.tx_channel_irq, .rx_channel_irq, .link_change_irq, .combined_cpu_irq, .irq_cause_vector);

// ---- mmicp_combiner_test.sv ----
// testbench: registers, gating, pacing and power states of the combiner
`timescale 1ns/10ps
module mmicp_combiner_test;
	logic mclk = 1'b0, rst = 1'b1, run = 1'b1, pll_tick = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic avs_waitrequest, combined_cpu_irq, status_irq;
	logic [19:0] src = 20'h0, irq_cause_vector;
	int miscompares = 0, n_checks = 0, edges;
	always #20 mclk = run ? ~mclk : mclk;
	always @(posedge mclk) pll_tick <= ~pll_tick;
	mmicp_combiner dut (.mclk, .rst, .pll_tick, .tx_channel_irq(src[7:0]),
		.rx_channel_irq(src[15:8]), .counter_overflow_irq(src[16]), .descriptor_error_irq(src[17]),
		.link_change_irq({1'b0, src[18]}), .mgmt_cmd_done_irq({src[19], 1'b0}), .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
		.combined_cpu_irq, .irq_cause_vector, .status_irq);
	mmicp_cpu_intc u_cpu (.mclk, .rst, .irq_in(combined_cpu_irq), .edges);
	// ============================================================
	// tasks
	task automatic ck(input string n, input logic [31:0] e, input logic [31:0] a);
		n_checks++;
		if (a !== e) begin
			$display("[FAIL] %s expected %h seen %h", n, e, a);
			miscompares++;
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge mclk); while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task automatic rk(input string n, input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		ck(n, e, q);
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// ============================================================
	// sequence
	initial begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		rk("gate rst", 4'h4, 32'h0);
		rk("pace rst", 4'h8, 32'h0);
		bus(1'b1, 4'h8, 32'hFFFFFFFF);
		rk("pace max", 4'h8, 32'h0001FFFF);
		bus(1'b1, 4'h8, 32'h0);
		bus(1'b1, 4'h4, 32'hFFFFFFFE);
		rk("gate rsvd", 4'h4, 32'h0);
		rk("unmapped", 4'h1, 32'h0);
		for (int i = 0; i < 20; i++) begin
			src <= 20'h1 << i;
			repeat (3) @(posedge mclk);
			ck("cause", 32'(src), 32'(irq_cause_vector));
			ck("gated", 32'h0, 32'(combined_cpu_irq));
			bus(1'b1, 4'h4, 32'h1);
			// one extra edge so the edge counter has settled
			repeat (3) @(posedge mclk);
			ck("merged", 32'h1, 32'(combined_cpu_irq));
			ck("edges", 32'(i + 1), 32'(edges));
			bus(1'b1, 4'h4, 32'h0);
		end
		bus(1'b1, 4'h4, 32'h1);
		repeat (3) @(posedge mclk);
		ck("re-edge", 32'h15, 32'(edges));
		bus(1'b1, 4'h4, 32'h0);
		ck("masked", 32'h0, 32'(status_irq));
		bus(1'b1, 4'h0, 32'h7);
		repeat (2) @(posedge mclk);
		ck("status irq", 32'h1, 32'(status_irq));
		bus(1'b1, 4'hC, 32'h7);
		rk("status w1c", 4'hC, 32'h0);
		ck("status low", 32'h0, 32'(status_irq));
		bus(1'b1, 4'h8, 32'h3);
		bus(1'b1, 4'h4, 32'h1);
		repeat (22) @(posedge mclk);
		ck("paced", 32'h0, 32'(combined_cpu_irq));
		bus(1'b1, 4'h4, 32'h1);
		repeat (18) @(posedge mclk);
		ck("pace end", 32'h1, 32'(combined_cpu_irq));
		ck("one edge", 32'h16, 32'(edges));
		// idle: clock parked high, state must survive
		@(posedge mclk) run <= 1'b0;
		#400 run = 1'b1;
		rk("idle gate", 4'h4, 32'h1);
		rk("idle pace", 4'h8, 32'h3);
		src <= 20'h0;
		@(posedge mclk) rst <= 1'b1;
		repeat (3) @(posedge mclk);
		rst <= 1'b0;
		ck("rst irq", 32'h0, 32'(combined_cpu_irq));
		rk("rst gate", 4'h4, 32'h0);
		rk("rst pace", 4'h8, 32'h0);
		test_done();
	end
	// about thirteen times the expected run
	initial begin
		#200000;
		miscompares++;
		test_done();
	end
endmodule
